// File: inc/sdadc_pkg.sv
// constants shared by the converter control block and its clock divider
package sdadc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] CTRL_A_OFS = 8'h00;
  localparam logic [7:0] CTRL_B_OFS = 8'h04;
  localparam logic [7:0] CLK_SEL_OFS = 8'h08;
  localparam logic [7:0] RES_LOW_OFS = 8'h0c;
  localparam logic [7:0] RES_MID_OFS = 8'h10;
  localparam logic [7:0] RES_HIGH_OFS = 8'h14;
  localparam logic [7:0] IRQ_CTRL_OFS = 8'h18;
  localparam logic [7:0] AMP_CHAN_OFS = 8'h1c;
  // control register a fields
  localparam int FILTER_RESET_BIT = 7;
  localparam int SLEEP_BIT = 6;
  localparam int POWER_DOWN_BIT = 5;
  localparam int RATE_LSB = 2;
  localparam int REF_SEL_BIT = 0;
  localparam logic [7:0] CTRL_A_RST = 8'h20;
  localparam logic [7:0] CTRL_A_MASK = 8'hfd;
  // control register b fields
  localparam int MODE_LSB = 5;
  localparam int BUF_N_BIT = 4;
  localparam int BUF_P_BIT = 3;
  localparam int LATCH_BIT = 2;
  localparam int EOC_BIT = 1;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  // irq control fields
  localparam int GIE_BIT = 0;
  localparam int CIE_BIT = 1;
  localparam int IRQ_FLAG_BIT = 2;
  // divider code that passes the system clock straight through
  localparam logic [4:0] DIV_BYPASS = 5'h1f;
  // converter clock ratios and the longest oversampling ratio
  localparam logic [4:0] ADC_DIV_SLOW = 5'd30;
  localparam logic [4:0] ADC_DIV_FAST = 5'd12;
  localparam logic [15:0] OSR_MAX = 16'd16384;
  // channel codes that reach the on-chip temperature sensor
  localparam logic [2:0] TEMP_POS_CODE = 3'h6;
  localparam logic [2:0] TEMP_NEG_CODE = 3'h6;
  // saturation limits of the 24-bit result
  localparam logic [23:0] RES_MAX = 24'h7fffff;
  localparam logic [23:0] RES_MIN = 24'h800000;
  // operating modes in priority order
  typedef enum logic [1:0] {MODE_OFF, MODE_SLEEP, MODE_RESET, MODE_RUN} mode_t;
endpackage : sdadc_pkg

// File: rtl/conv_clk_divider.sv
// converter master clock enable derived from the system clock
`timescale 1ns/100ps
module conv_clk_divider (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] div_code,
  output logic mclk_en
);
  // counts system clocks inside one half period pair
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] last;

  // divide by two then by code plus one, or pass through on the bypass code
  always_comb begin
    last = {div_code, 1'b1};
    cnt_next = cnt_reg + 6'd1;
    mclk_en = 1'b0;
    if (div_code == sdadc_pkg::DIV_BYPASS) begin
      mclk_en = 1'b1;
      cnt_next = 6'd0;
    end else if (cnt_reg >= last) begin
      mclk_en = 1'b1;
      cnt_next = 6'd0;
    end
  end

  // register stage only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= 6'd0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  chk_div_bypass: assert property (@(posedge clk) disable iff (!resetn)
    div_code == sdadc_pkg::DIV_BYPASS |-> mclk_en) else $error("bypass code lost enable");
  chk_div_spacing: assert property (@(posedge clk) disable iff (!resetn)
    (div_code != sdadc_pkg::DIV_BYPASS && mclk_en) ##1 $stable(div_code) |-> !mclk_en)
    else $error("divided enable too close");
endmodule : conv_clk_divider

// File: rtl/sigma_delta_adc_control.sv
// control and result path of the 24-bit delta-sigma converter
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module sigma_delta_adc_control #(
  parameter int FILT_W = 28 // width of the raw filter output, wider than the result
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic signed [FILT_W-1:0] filter_data, // raw decimator output
  output logic mclk_en, // converter master clock enable
  output logic pga_power_on,
  output logic mod_power_on,
  output logic sinc_reset,
  output logic ref_external,
  output logic vref_buf_p,
  output logic vref_buf_n,
  output logic [2:0] positive_channel_select,
  output logic [2:0] negative_channel_select,
  output logic temp_sensor_route,
  output logic conv_done, // one pulse per finished conversion
  output logic conv_irq
);
  // software registers
  logic [7:0] conv_control_reg_a, ctrl_a_next;
  logic [7:0] conv_control_reg_b, ctrl_b_next;
  logic [4:0] conv_clock_select_reg, clk_sel_next;
  logic [2:0] irq_ctrl_reg, irq_ctrl_next;
  logic [5:0] amp_channel_reg, amp_chan_next;
  logic [23:0] result_reg, result_next;
  // bus data phase state
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  // conversion timing state
  logic [4:0] tick_reg, tick_next;
  logic [15:0] samp_reg, samp_next;
  // decoded controls
  sdadc_pkg::mode_t mode;
  logic addr_phase, latched, adc_tick, b_wr, eoc_clr_wr, flag_clr_wr;
  logic [4:0] adc_div;
  logic [15:0] conv_len;
  logic [23:0] sat_value;

  // register read mux, used at address phase
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (a)
      sdadc_pkg::CTRL_A_OFS: read_byte = conv_control_reg_a;
      sdadc_pkg::CTRL_B_OFS: read_byte = conv_control_reg_b;
      sdadc_pkg::CLK_SEL_OFS: read_byte = {3'h0, conv_clock_select_reg};
      sdadc_pkg::RES_LOW_OFS: read_byte = result_reg[7:0];
      sdadc_pkg::RES_MID_OFS: read_byte = result_reg[15:8];
      sdadc_pkg::RES_HIGH_OFS: read_byte = result_reg[23:16];
      sdadc_pkg::IRQ_CTRL_OFS: read_byte = {5'h0, irq_ctrl_reg};
      sdadc_pkg::AMP_CHAN_OFS: read_byte = {2'h0, amp_channel_reg};
      default: read_byte = 8'h00; // unmapped reads as zero
    endcase
  endfunction : read_byte

  // clamp the wide filter output into the 24-bit range
  function automatic logic [23:0] saturate(input logic signed [FILT_W-1:0] v);
    if (v > $signed({{(FILT_W-24){1'b0}}, sdadc_pkg::RES_MAX})) begin
      saturate = sdadc_pkg::RES_MAX;
    end else if (v < $signed({{(FILT_W-24){1'b1}}, sdadc_pkg::RES_MIN})) begin
      saturate = sdadc_pkg::RES_MIN;
    end else begin
      saturate = v[23:0]; // sign bit lands in bit 23
    end
  endfunction : saturate

  // master clock enable from the divider code
  conv_clk_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .div_code(conv_clock_select_reg),
    .mclk_en(mclk_en)
  );

  // mode priority: power-down, then sleep, then filter reset
  always_comb begin
    if (conv_control_reg_a[sdadc_pkg::POWER_DOWN_BIT]) begin
      mode = sdadc_pkg::MODE_OFF;
    end else if (conv_control_reg_a[sdadc_pkg::SLEEP_BIT]) begin
      mode = sdadc_pkg::MODE_SLEEP;
    end else if (conv_control_reg_a[sdadc_pkg::FILTER_RESET_BIT]) begin
      mode = sdadc_pkg::MODE_RESET;
    end else begin
      mode = sdadc_pkg::MODE_RUN;
    end
  end

  // analog front end controls follow the mode and config bits
  always_comb begin
    pga_power_on = (mode != sdadc_pkg::MODE_OFF);
    mod_power_on = (mode == sdadc_pkg::MODE_RESET) || (mode == sdadc_pkg::MODE_RUN);
    sinc_reset = (mode != sdadc_pkg::MODE_RUN);
    ref_external = conv_control_reg_a[sdadc_pkg::REF_SEL_BIT];
    vref_buf_p = conv_control_reg_b[sdadc_pkg::BUF_P_BIT];
    vref_buf_n = conv_control_reg_b[sdadc_pkg::BUF_N_BIT];
    positive_channel_select = amp_channel_reg[2:0];
    negative_channel_select = amp_channel_reg[5:3];
    temp_sensor_route = (amp_channel_reg[2:0] == sdadc_pkg::TEMP_POS_CODE) &&
                        (amp_channel_reg[5:3] == sdadc_pkg::TEMP_NEG_CODE);
  end

  // conversion timing: master clock / 30 or / 12 gives the modulator rate,
  // oversampling ratio times chop count gives the word period
  always_comb begin
    latched = conv_control_reg_b[sdadc_pkg::LATCH_BIT];
    adc_div = conv_control_reg_b[sdadc_pkg::MODE_LSB+1] ? sdadc_pkg::ADC_DIV_FAST : sdadc_pkg::ADC_DIV_SLOW;
    conv_len = sdadc_pkg::OSR_MAX >> conv_control_reg_a[sdadc_pkg::RATE_LSB +: 3];
    if (!conv_control_reg_b[sdadc_pkg::MODE_LSB+2]) begin
      conv_len = {conv_len[14:0], 1'b0}; // normal mode chops twice
    end
    adc_tick = 1'b0;
    tick_next = tick_reg;
    samp_next = samp_reg;
    conv_done = 1'b0;
    if (mode != sdadc_pkg::MODE_RUN) begin // filter held in power-down, sleep and filter reset; runs only when all three bits are low
      tick_next = 5'd0;
      samp_next = 16'd0;
    end else if (mclk_en) begin
      // >= so a switch from /30 to /12 mid-count wraps at once instead of running past the end
      if (tick_reg >= adc_div - 5'd1) begin
        tick_next = 5'd0;
        adc_tick = 1'b1;
      end else begin
        tick_next = tick_reg + 5'd1;
      end
    end
    if (adc_tick) begin
      if (samp_reg >= conv_len - 16'd1) begin // restarts with no software start
        samp_next = 16'd0;
        conv_done = 1'b1;
      end else begin
        samp_next = samp_reg + 16'd1;
      end
    end
    sat_value = saturate(filter_data);
    // a latched result ignores new words; conversion keeps running
    result_next = (conv_done && !latched) ? sat_value : result_reg;
  end

  // conversion state registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_reg <= 5'd0;
      samp_reg <= 16'd0;
      result_reg <= 24'h000000;
    end else begin
      tick_reg <= tick_next;
      samp_reg <= samp_next;
      result_reg <= result_next;
    end
  end

  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // address phase capture and register writes in the data phase
  always_comb begin
    addr_phase = hsel && htrans[1] && hready;
    wr_pend_next = addr_phase && hwrite;
    addr_next = addr_phase ? haddr[7:0] : addr_reg;
    hrdata_next = (addr_phase && !hwrite) ? {24'h0, read_byte(haddr[7:0])} : hrdata_reg;
    ctrl_a_next = conv_control_reg_a;
    ctrl_b_next = conv_control_reg_b;
    clk_sel_next = conv_clock_select_reg;
    irq_ctrl_next = irq_ctrl_reg;
    amp_chan_next = amp_channel_reg;
    b_wr = wr_pend_reg && (addr_reg == sdadc_pkg::CTRL_B_OFS);
    eoc_clr_wr = b_wr && !hwdata[sdadc_pkg::EOC_BIT];
    flag_clr_wr = wr_pend_reg && (addr_reg == sdadc_pkg::IRQ_CTRL_OFS) && !hwdata[sdadc_pkg::IRQ_FLAG_BIT];
    if (wr_pend_reg) begin
      case (addr_reg)
        sdadc_pkg::CTRL_A_OFS: ctrl_a_next = hwdata[7:0] & sdadc_pkg::CTRL_A_MASK;
        sdadc_pkg::CTRL_B_OFS: ctrl_b_next = {hwdata[7:2], conv_control_reg_b[1:0]};
        sdadc_pkg::CLK_SEL_OFS: clk_sel_next = hwdata[4:0];
        sdadc_pkg::IRQ_CTRL_OFS: irq_ctrl_next[1:0] = hwdata[1:0];
        sdadc_pkg::AMP_CHAN_OFS: amp_chan_next = hwdata[5:0];
        default: ; // results are read only, others ignored
      endcase
    end
    // end flag: software zero clears, writing one keeps it; a new end wins
    if (eoc_clr_wr) begin
      ctrl_b_next[sdadc_pkg::EOC_BIT] = 1'b0;
    end
    if (flag_clr_wr) begin
      irq_ctrl_next[sdadc_pkg::IRQ_FLAG_BIT] = 1'b0;
    end
    if (conv_done && !latched) begin
      ctrl_b_next[sdadc_pkg::EOC_BIT] = 1'b1;
      irq_ctrl_next[sdadc_pkg::IRQ_FLAG_BIT] = 1'b1;
    end
  end

  // bus and control registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      conv_control_reg_a <= sdadc_pkg::CTRL_A_RST; // powered down from reset
      conv_control_reg_b <= sdadc_pkg::CTRL_B_RST;
      conv_clock_select_reg <= 5'h00;
      irq_ctrl_reg <= 3'h0;
      amp_channel_reg <= 6'h00;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
      conv_control_reg_a <= ctrl_a_next;
      conv_control_reg_b <= ctrl_b_next;
      conv_clock_select_reg <= clk_sel_next;
      irq_ctrl_reg <= irq_ctrl_next;
      amp_channel_reg <= amp_chan_next;
    end
  end

  // interrupt only when both enables are set; polling works without them
  assign conv_irq = irq_ctrl_reg[sdadc_pkg::IRQ_FLAG_BIT] && irq_ctrl_reg[sdadc_pkg::GIE_BIT] &&
                    irq_ctrl_reg[sdadc_pkg::CIE_BIT];

  // interrupt gating and the two sticky flags
  chk_irq_enables: assert property (@(posedge clk) disable iff (!resetn)
    conv_irq |-> irq_ctrl_reg[sdadc_pkg::GIE_BIT] && irq_ctrl_reg[sdadc_pkg::CIE_BIT])
    else $error("interrupt without both enables");
  chk_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && !latched && irq_ctrl_reg[sdadc_pkg::GIE_BIT] && irq_ctrl_reg[sdadc_pkg::CIE_BIT] &&
    !(wr_pend_reg && addr_reg == sdadc_pkg::IRQ_CTRL_OFS) |=> conv_irq)
    else $error("enabled interrupt not raised");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
    irq_ctrl_reg[sdadc_pkg::IRQ_FLAG_BIT] && !flag_clr_wr |=> irq_ctrl_reg[sdadc_pkg::IRQ_FLAG_BIT])
    else $error("request flag dropped by hardware");
  chk_eoc_sticky: assert property (@(posedge clk) disable iff (!resetn)
    conv_control_reg_b[sdadc_pkg::EOC_BIT] && !eoc_clr_wr |=> conv_control_reg_b[sdadc_pkg::EOC_BIT])
    else $error("end flag dropped by hardware");
  chk_eoc_clear: assert property (@(posedge clk) disable iff (!resetn)
    eoc_clr_wr && !(conv_done && !latched) |=> !conv_control_reg_b[sdadc_pkg::EOC_BIT])
    else $error("software zero left end flag set");
  chk_eoc_set: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && !latched |=> conv_control_reg_b[sdadc_pkg::EOC_BIT] && irq_ctrl_reg[sdadc_pkg::IRQ_FLAG_BIT])
    else $error("conversion end not flagged");
  // result register: frozen while latched, otherwise changed only at a word end
  chk_latch_freeze: assert property (@(posedge clk) disable iff (!resetn)
    latched && !conv_control_reg_b[sdadc_pkg::EOC_BIT] |=> $stable(result_reg) &&
    !conv_control_reg_b[sdadc_pkg::EOC_BIT]) else $error("latched result changed");
  chk_result_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(conv_done && !latched) |=> $stable(result_reg)) else $error("result changed between conversions");
  // power modes and the conversion counters
  chk_pd_off: assert property (@(posedge clk) disable iff (!resetn)
    conv_control_reg_a[sdadc_pkg::POWER_DOWN_BIT] |-> !pga_power_on && !mod_power_on && !conv_done)
    else $error("power-down left circuits on");
  chk_sleep_mode: assert property (@(posedge clk) disable iff (!resetn)
    !conv_control_reg_a[sdadc_pkg::POWER_DOWN_BIT] && conv_control_reg_a[sdadc_pkg::SLEEP_BIT]
    |-> pga_power_on && !mod_power_on) else $error("sleep priority wrong");
  chk_reset_hold: assert property (@(posedge clk) disable iff (!resetn)
    sinc_reset |=> samp_reg == 16'd0 && tick_reg == 5'd0) else $error("filter ran during reset");
  chk_run_ticks: assert property (@(posedge clk) disable iff (!resetn)
    mode == sdadc_pkg::MODE_RUN && mclk_en && tick_reg < adc_div - 5'd1 |=> tick_reg == $past(tick_reg) + 5'd1)
    else $error("modulator tick counter stalled");
  chk_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
    conv_done |=> !conv_done) else $error("conversion end pulse too long");
  // saturation at both ends of the range
  chk_sat_max: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && !latched && filter_data > $signed(FILT_W'(sdadc_pkg::RES_MAX)) |=> result_reg == sdadc_pkg::RES_MAX)
    else $error("positive overflow not clamped");
  chk_sat_min: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && !latched && filter_data[FILT_W-1] && !(&filter_data[FILT_W-2:23])
    |=> result_reg == sdadc_pkg::RES_MIN) else $error("negative overflow not clamped");
endmodule : sigma_delta_adc_control

// File: verif/front_end_model.sv
// behavioural analog front end and decimator feeding the control block
`timescale 1ns/100ps
module front_end_model #(
  parameter int FILT_W = 28 // raw filter word width
) (
  input wire logic clk,
  input wire logic mod_power_on,
  input wire logic sinc_reset,
  input wire logic signed [FILT_W-1:0] sample, // value the analog side settles to
  output logic signed [FILT_W-1:0] filter_data
);
  initial filter_data = '0;
  // filter idle: the word churns each cycle so a stale value never passes for a result
  always @(posedge clk) begin
    if (mod_power_on && !sinc_reset) begin
      filter_data <= sample;
    end else begin
      filter_data <= ~filter_data;
    end
  end
endmodule : front_end_model

// File: verif/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, mclk_en, conv_done, conv_irq, pga_on, mod_on, sinc_rst;
  logic ref_ext, buf_p, buf_n, temp_route;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] pos_sel, neg_sel;
  logic signed [27:0] sample, filter_data;
  int n_errors = 0;
  int comparisons = 0;
  sigma_delta_adc_control uut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .filter_data(filter_data), .mclk_en(mclk_en),
    .pga_power_on(pga_on), .mod_power_on(mod_on), .sinc_reset(sinc_rst), .ref_external(ref_ext),
    .vref_buf_p(buf_p), .vref_buf_n(buf_n), .positive_channel_select(pos_sel),
    .negative_channel_select(neg_sel), .temp_sensor_route(temp_route), .conv_done(conv_done),
    .conv_irq(conv_irq));
  front_end_model fe (.clk(clk), .mod_power_on(mod_on), .sinc_reset(sinc_rst), .sample(sample),
    .filter_data(filter_data));
  // verdict, also reached by every timeout
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // the one comparison of the bench
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait for a signal sampled high at a rising edge
  task automatic wait_hi(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      if (s === 1'b1) break;
    end
    if (i == lim) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_hi
  // one single AHB-Lite word transfer, read data kept in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_hi(hreadyout, 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_hi(hreadyout, 20);
    rd = hrdata;
    // let the register update land before anyone looks at the ports
    @(negedge clk);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask : rdc
  // expected result: clip to the 24-bit range, never wrap
  function automatic logic [23:0] sat(input logic signed [27:0] v);
    if (v > 28'sd8388607) return sdadc_pkg::RES_MAX;
    if (v < -28'sd8388608) return sdadc_pkg::RES_MIN;
    return v[23:0];
  endfunction : sat
  // gap in cycles between the second and third divider pulse
  task automatic gap_of(output int g);
    int n;
    int p;
    n = 0;
    p = 0;
    g = 0;
    for (int i = 0; i < 300 && n < 3; i++) begin
      @(posedge clk);
      if (mclk_en === 1'b1) begin
        if (n > 0) g = i - p;
        p = i;
        n++;
      end
    end
  endtask : gap_of
  // expected word period in system clocks with the master clock enabled every cycle
  function automatic int conv_cycles(input logic [7:0] m, input logic [2:0] r);
    int n;
    n = 32'(sdadc_pkg::OSR_MAX) >> r;
    if (!m[7]) n = 2 * n;
    return n * (m[6] ? 32'(sdadc_pkg::ADC_DIV_FAST) : 32'(sdadc_pkg::ADC_DIV_SLOW));
  endfunction : conv_cycles
  // cycles from one conversion end to the next, bounded
  task automatic period_of(output int p);
    wait_hi(conv_done, 20000);
    for (p = 1; p < 20000; p++) begin
      @(posedge clk);
      if (conv_done === 1'b1) break;
    end
    if (p == 20000) begin
      n_errors++;
      complete_run();
    end
  endtask : period_of
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    logic [27:0] vals [5];
    logic [4:0] codes [4];
    logic [7:0] modes [3];
    logic [1:0] ie;
    logic [23:0] exp;
    int g;
    // corner words: just over, exact limits, just under, zero
    vals = '{28'h0800000, 28'h07fffff, 28'hf800000, 28'hf7fffff, 28'h0};
    codes = '{5'h00, 5'h05, 5'h1e, 5'h1f};
    // normal /12 with buffer n, low latency /30 with buffer p, normal /30
    modes = '{8'h50, 8'h88, 8'h00};
    {resetn, hsel, hwrite, htrans, haddr, hwdata, sample} = '0;
    void'($urandom(66504));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rdc(sdadc_pkg::CTRL_A_OFS, 32'h20, "ctrl_a reset");
    rdc(sdadc_pkg::CTRL_B_OFS, 32'h0, "ctrl_b reset");
    rdc(8'h40, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
    bus(sdadc_pkg::AMP_CHAN_OFS, 1'b1, 32'h36);
    chk("temp route", 32'h1, {31'h0, temp_route});
    chk("channels", 32'h36, {26'h0, neg_sel, pos_sel});
    bus(sdadc_pkg::CLK_SEL_OFS, 1'b1, 32'h1f);
    bus(sdadc_pkg::CTRL_B_OFS, 1'b1, 32'hc0);
    bus(sdadc_pkg::CTRL_A_OFS, 1'b1, 32'h1d);
    chk("ref external", 32'h1, {31'h0, ref_ext});
    bus(sdadc_pkg::CTRL_A_OFS, 1'b1, 32'h9d);
    bus(sdadc_pkg::CTRL_A_OFS, 1'b1, 32'h1d);
    $display("test setup done");
    // corner words then random ones, each with a random pair of interrupt enables
    for (int k = 0; k < 8; k++) begin
      sample <= (k < 5) ? vals[k] : 28'($urandom);
      ie = 2'($urandom);
      bus(sdadc_pkg::IRQ_CTRL_OFS, 1'b1, {30'h0, ie});
      wait_hi(conv_done, 8000);
      exp = sat(sample);
      @(negedge clk);
      chk("conv_irq", {31'h0, &ie}, {31'h0, conv_irq});
      rdc(sdadc_pkg::IRQ_CTRL_OFS, {29'h1, ie}, "irq flag");
      bus(sdadc_pkg::CTRL_B_OFS, 1'b1, 32'hc6);
      rdc(sdadc_pkg::CTRL_B_OFS, 32'hc6, "eoc set");
      rdc(sdadc_pkg::RES_LOW_OFS, {24'h0, exp[7:0]}, "low byte");
      rdc(sdadc_pkg::RES_MID_OFS, {24'h0, exp[15:8]}, "mid byte");
      rdc(sdadc_pkg::RES_HIGH_OFS, {24'h0, exp[23:16]}, "high byte");
      bus(sdadc_pkg::CTRL_B_OFS, 1'b1, 32'hc4);
      bus(sdadc_pkg::IRQ_CTRL_OFS, 1'b1, {30'h0, ie});
      sample <= ~sample;
      wait_hi(conv_done, 8000);
      @(negedge clk);
      rdc(sdadc_pkg::CTRL_B_OFS, 32'hc4, "eoc latched");
      chk("irq latched", 32'h0, {31'h0, conv_irq});
      rdc(sdadc_pkg::RES_LOW_OFS, {24'h0, exp[7:0]}, "frozen low");
      bus(sdadc_pkg::CTRL_B_OFS, 1'b1, 32'hc0);
      $display("test conversion %0d done", k);
    end
    // word period in each latency mode and divide ratio, buffer enables riding along
    foreach (modes[j]) begin
      bus(sdadc_pkg::CTRL_B_OFS, 1'b1, {24'h0, modes[j]});
      chk("vref buffers", {30'h0, modes[j][4:3]}, {30'h0, buf_n, buf_p});
      period_of(g);
      chk("word period", conv_cycles(modes[j], 3'h7), 32'(g));
    end
    $display("test word period done");
    foreach (codes[j]) begin
      bus(sdadc_pkg::CLK_SEL_OFS, 1'b1, {27'h0, codes[j]});
      gap_of(g);
      chk("mclk gap", (codes[j] == 5'h1f) ? 32'd1 : 32'(2 * (codes[j] + 1)), 32'(g));
    end
    $display("test divider done");
    // reset in mid-run, converter running, returns the controls to their reset state
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("reset outputs", 32'h1, {28'h0, ref_ext, pga_on, mod_on, sinc_rst});
    rdc(sdadc_pkg::CLK_SEL_OFS, 32'h0, "clk_sel reset");
    $display("test mid-run reset done");
    // every combination of power-down, sleep and filter reset
    for (int k = 0; k < 8; k++) begin
      bus(sdadc_pkg::CTRL_A_OFS, 1'b1, {24'h0, 3'(k), 5'h1d});
      chk("mode outputs", {29'h0, !k[0], !k[0] && !k[1], k[0] || k[1] || k[2]},
        {29'h0, pga_on, mod_on, sinc_rst});
    end
    $display("test modes done");
    complete_run();
  end
endmodule : testbench
